// ### design/refclk_path.sv
/*
 * One reference clock path: free-running source, source mux with
 * glitch-free switching, and programmable divider.
 * Assumes all source clocks are slow levels synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module refclk_path #(
	parameter int N_CH  = 17,
	parameter int SEL_W = 5,
	parameter int DIV_W = 4
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// sources
	input  wire logic [N_CH-1:0]  rec_clk_i,
	input  wire logic             ext_clk_i,
	input  wire logic             ext_e1_i,
	// control
	input  wire logic [SEL_W-1:0] sel_i,
	input  wire logic [DIV_W-1:0] div_i,
	// result
	output logic                  clk_o,
	output logic                  busy_o
);
	typedef enum logic {ST_RUN = 1'b0, ST_SWITCH = 1'b1} path_state_t;

	localparam logic [SEL_W-1:0] IDX_FREE = SEL_W'(N_CH + 1);

	path_state_t      state_q, state_d;
	logic [SEL_W-1:0] cur_q, cur_d;
	logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
	logic [7:0]       free_cnt_q, free_cnt_d;
	logic             free_q, free_d;
	logic             prev_q, prev_d;
	logic             out_q, out_d;
	logic [N_CH+1:0]  src_vec;
	logic             lvl;
	logic             rise;
	logic [7:0]       half;

	assign src_vec = {free_q, ext_clk_i, rec_clk_i};
	assign lvl     = (cur_q <= IDX_FREE) ? src_vec[cur_q] : free_q;
	assign rise    = lvl & ~prev_q;
	assign half    = ext_e1_i ? refclk_pkg::FREE_E1_HALF : refclk_pkg::FREE_T1_HALF;
	assign clk_o   = out_q;
	assign busy_o  = (state_q == ST_SWITCH);

	always_comb begin
		free_cnt_d = free_cnt_q + 8'h01;
		free_d     = free_q;
		if (free_cnt_q >= half - 8'h01) begin
			free_cnt_d = 8'h00;
			free_d     = ~free_q;
		end
		state_d   = state_q;
		cur_d     = cur_q;
		div_cnt_d = div_cnt_q;
		out_d     = out_q;
		prev_d    = lvl;
		// a switch is taken only while the output sits low, so no short pulse escapes
		if (state_q == ST_SWITCH && !out_q) begin
			cur_d     = sel_i;
			div_cnt_d = '0;
			prev_d    = 1'b1;
			state_d   = ST_RUN;
		end else begin
			if (rise) begin
				if (div_cnt_q >= div_i) begin
					div_cnt_d = '0;
					out_d     = ~out_q;
				end else begin
					div_cnt_d = div_cnt_q + DIV_W'(1);
				end
			end
			case (state_q)
				ST_RUN: begin
					if (sel_i != cur_q) begin
						state_d = ST_SWITCH;
					end
				end
				ST_SWITCH: begin
					state_d = ST_SWITCH;
				end
				default: begin
					state_d = ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q    <= ST_RUN;
			cur_q      <= IDX_FREE;
			div_cnt_q  <= '0;
			free_cnt_q <= 8'h00;
			free_q     <= 1'b0;
			prev_q     <= 1'b1;
			out_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			cur_q      <= cur_d;
			div_cnt_q  <= div_cnt_d;
			free_cnt_q <= free_cnt_d;
			free_q     <= free_d;
			prev_q     <= prev_d;
			out_q      <= out_d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_switch_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		(cur_q != $past(cur_q)) |-> (!clk_o && !$past(clk_o));
	endproperty
	a_switch_low: assert property (p_switch_low) else $error("source switched while output high");

	property p_toggle_cause;
		@(posedge clk_i) disable iff (!rst_b_i)
		$changed(clk_o) |-> $past(rise);
	endproperty
	a_toggle_cause: assert property (p_toggle_cause) else $error("output toggled without source edge");

	property p_div_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		(rise && !busy_o && div_cnt_q < div_i) |=> $stable(clk_o) && (div_cnt_q == $past(div_cnt_q) + DIV_W'(1));
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divider toggled early");

endmodule // refclk_path
`default_nettype wire

// ### design/refclk_pkg.sv
/*
 * Constants for the reference clock output select block: register offsets,
 * field positions, reset values and free-running clock timing.
 * Assumes a 125 MHz system clock and an 8-bit register port.
 */
// Notes on behaviour
// - output A carries a channel recovered clock, external input A, or free-running clock.
// - software programs the frequency seen on output A through a divider field.
// - config A bit 6 enables output A; disabled means output A floats.
// - output B carries a channel recovered clock, external input B, or free-running clock.
// - config B bit 6 enables output B; disabled means output B floats.
// - differential mode with match select low floats all receivers, ignoring termination fields.
// - differential mode with match select high applies each channel's termination and 120-ohm bit.
// - common-mode outputs are active only while the common-mode enable pin is high.
package refclk_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_REF_A_CFG   = 8'h00;
	localparam logic [7:0] OFS_REF_B_CFG   = 8'h01;
	localparam logic [7:0] OFS_REF_A_ROUTE = 8'h02;
	localparam logic [7:0] OFS_REF_B_ROUTE = 8'h03;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	localparam logic [7:0] OFS_TERM_BASE   = 8'h10;

	// ************************************************************
	// fields
	// ************************************************************
	localparam int CFG_EN_BIT      = 6;
	localparam int CFG_E1_BIT      = 5;
	localparam int CFG_DIV_LSB     = 0;
	localparam int DIV_W           = 4;
	localparam int ROUTE_KIND_LSB  = 5;
	localparam int ROUTE_CH_LSB    = 0;
	localparam int SEL_W           = 5;
	localparam int TERM_FIELD_LSB  = 0;
	localparam int TERM_W          = 3;
	localparam int TERM_120_BIT    = 4;

	localparam logic [1:0] KIND_RECOVERED = 2'h0;
	localparam logic [1:0] KIND_EXTERNAL  = 2'h1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_REF_CFG   = 8'h00;
	localparam logic [7:0] RST_REF_ROUTE = 8'h40;
	localparam logic [7:0] RST_TERM_CFG  = 8'h00;

	// ************************************************************
	// free-running clock timing
	// ************************************************************
	localparam int CLK_KHZ     = 125000;
	localparam int FREE_T1_KHZ = 1544;
	localparam int FREE_E1_KHZ = 2048;
	localparam logic [7:0] FREE_T1_HALF = 8'(CLK_KHZ / (2 * FREE_T1_KHZ));
	localparam logic [7:0] FREE_E1_HALF = 8'(CLK_KHZ / (2 * FREE_E1_KHZ));

endpackage

// ### design/refclk_sel.sv
/*
 * Reference clock output select: two switchable reference clock outputs,
 * per-channel receive termination control and common-mode output gating,
 * the first two programmed over a plain 8-bit register port, the last by pin.
 * Assumes every input is synchronous to clk_i and that the recovered and
 * external clocks are far slower than clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module refclk_sel #(
	parameter int N_CH = 17
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	// register port
	input  wire logic [7:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	// clock sources
	input  wire logic [N_CH-1:0]   rec_clk_i,
	input  wire logic              ext_clock_in_a_i,
	input  wire logic              ext_clock_in_b_i,
	// reference outputs
	output logic                   ref_out_a_o,
	output logic                   ref_out_a_oe_o,
	output logic                   ref_out_b_o,
	output logic                   ref_out_b_oe_o,
	// receive termination
	input  wire logic              rx_diff_mode_i,
	input  wire logic              rx_impedance_match_select_i,
	output logic [N_CH*3-1:0]      rx_term_o,
	output logic [N_CH-1:0]        rx_120ohm_select_o,
	output logic [N_CH-1:0]        rx_hiz_o,
	// common mode
	input  wire logic              common_mode_out_enable_pin_i,
	output logic [1:0]             common_mode_outputs_en_o
);
	localparam int SEL_W = refclk_pkg::SEL_W;
	localparam int DIV_W = refclk_pkg::DIV_W;

	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0] cfg_a_q, cfg_a_d;
	logic [7:0] cfg_b_q, cfg_b_d;
	logic [7:0] route_a_q, route_a_d;
	logic [7:0] route_b_q, route_b_d;
	logic [7:0] term_q [N_CH];
	logic [7:0] term_d [N_CH];
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] term_idx;
	logic       term_hit;
	logic       busy_a;
	logic       busy_b;
	logic       clk_a;
	logic       clk_b;

	assign term_idx = addr_i - refclk_pkg::OFS_TERM_BASE;
	assign term_hit = (addr_i >= refclk_pkg::OFS_TERM_BASE) && (term_idx < 8'(N_CH));

	always_comb begin
		cfg_a_d   = cfg_a_q;
		cfg_b_d   = cfg_b_q;
		route_a_d = route_a_q;
		route_b_d = route_b_q;
		term_d    = term_q;
		if (wr_i) begin
			case (addr_i)
				refclk_pkg::OFS_REF_A_CFG:   cfg_a_d   = wdata_i;
				refclk_pkg::OFS_REF_B_CFG:   cfg_b_d   = wdata_i;
				refclk_pkg::OFS_REF_A_ROUTE: route_a_d = wdata_i;
				refclk_pkg::OFS_REF_B_ROUTE: route_b_d = wdata_i;
				default: begin
					if (term_hit) begin
						term_d[term_idx[4:0]] = wdata_i;
					end
				end
			endcase
		end
	end

	// unmapped addresses and the cycles without a read return zero
	always_comb begin
		rdata_d = 8'h00;
		if (rd_i) begin
			case (addr_i)
				refclk_pkg::OFS_REF_A_CFG:   rdata_d = cfg_a_q;
				refclk_pkg::OFS_REF_B_CFG:   rdata_d = cfg_b_q;
				refclk_pkg::OFS_REF_A_ROUTE: rdata_d = route_a_q;
				refclk_pkg::OFS_REF_B_ROUTE: rdata_d = route_b_q;
				refclk_pkg::OFS_STATUS:      rdata_d = {4'h0, busy_b, busy_a, clk_b, clk_a};
				default: begin
					if (term_hit) begin
						rdata_d = term_q[term_idx[4:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cfg_a_q   <= refclk_pkg::RST_REF_CFG;
			cfg_b_q   <= refclk_pkg::RST_REF_CFG;
			route_a_q <= refclk_pkg::RST_REF_ROUTE;
			route_b_q <= refclk_pkg::RST_REF_ROUTE;
			rdata_q   <= 8'h00;
			for (int i = 0; i < N_CH; i++) begin
				term_q[i] <= refclk_pkg::RST_TERM_CFG;
			end
		end else begin
			cfg_a_q   <= cfg_a_d;
			cfg_b_q   <= cfg_b_d;
			route_a_q <= route_a_d;
			route_b_q <= route_b_d;
			rdata_q   <= rdata_d;
			term_q    <= term_d;
		end
	end

	assign rdata_o = rdata_q;

	// ************************************************************
	// source routing
	// ************************************************************
	// an out-of-range channel falls back to channel 0 rather than a dead source
	function automatic logic [SEL_W-1:0] route_idx(input logic [7:0] r);
		logic [1:0]       kind;
		logic [SEL_W-1:0] ch;
		kind = r[refclk_pkg::ROUTE_KIND_LSB +: 2];
		ch   = r[refclk_pkg::ROUTE_CH_LSB +: SEL_W];
		if (kind == refclk_pkg::KIND_RECOVERED) begin
			route_idx = (ch < SEL_W'(N_CH)) ? ch : '0;
		end else if (kind == refclk_pkg::KIND_EXTERNAL) begin
			route_idx = SEL_W'(N_CH);
		end else begin
			route_idx = SEL_W'(N_CH + 1);
		end
	endfunction

	refclk_path #(
		.N_CH  (N_CH),
		.SEL_W (SEL_W),
		.DIV_W (DIV_W)
	) u_path_a (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.rec_clk_i (rec_clk_i),
		.ext_clk_i (ext_clock_in_a_i),
		.ext_e1_i  (cfg_a_q[refclk_pkg::CFG_E1_BIT]),
		.sel_i     (route_idx(route_a_q)),
		.div_i     (cfg_a_q[refclk_pkg::CFG_DIV_LSB +: DIV_W]),
		.clk_o     (clk_a),
		.busy_o    (busy_a)
	);

	refclk_path #(
		.N_CH  (N_CH),
		.SEL_W (SEL_W),
		.DIV_W (DIV_W)
	) u_path_b (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.rec_clk_i (rec_clk_i),
		.ext_clk_i (ext_clock_in_b_i),
		.ext_e1_i  (cfg_b_q[refclk_pkg::CFG_E1_BIT]),
		.sel_i     (route_idx(route_b_q)),
		.div_i     (cfg_b_q[refclk_pkg::CFG_DIV_LSB +: DIV_W]),
		.clk_o     (clk_b),
		.busy_o    (busy_b)
	);

	// ************************************************************
	// output pins
	// ************************************************************
	// data is held low while disabled so the pad never sees a stale level
	assign ref_out_a_oe_o = cfg_a_q[refclk_pkg::CFG_EN_BIT];
	assign ref_out_a_o    = clk_a & cfg_a_q[refclk_pkg::CFG_EN_BIT];
	assign ref_out_b_oe_o = cfg_b_q[refclk_pkg::CFG_EN_BIT];
	assign ref_out_b_o    = clk_b & cfg_b_q[refclk_pkg::CFG_EN_BIT];

	assign common_mode_outputs_en_o = {2{common_mode_out_enable_pin_i}};

	// ************************************************************
	// receive termination
	// ************************************************************
	// single-ended mode leaves the match select pin out of it
	logic rx_float;
	assign rx_float = rx_diff_mode_i & ~rx_impedance_match_select_i;

	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			if (rx_float) begin
				rx_hiz_o[i]           = 1'b1;
				rx_term_o[i*3 +: 3]   = 3'h0;
				rx_120ohm_select_o[i] = 1'b0;
			end else begin
				rx_hiz_o[i]           = 1'b0;
				rx_term_o[i*3 +: 3]   = term_q[i][refclk_pkg::TERM_FIELD_LSB +: 3];
				rx_120ohm_select_o[i] = term_q[i][refclk_pkg::TERM_120_BIT];
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_oe_a;
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == refclk_pkg::OFS_REF_A_CFG) |=>
			(ref_out_a_oe_o == $past(wdata_i[6])) && (ref_out_a_oe_o || !ref_out_a_o);
	endproperty
	a_oe_a: assert property (p_oe_a) else $error("output A enable does not follow its write");

	property p_oe_b;
		@(posedge clk_i) disable iff (!rst_b_i)
		!ref_out_b_oe_o |-> !ref_out_b_o ##1 (!$past(wr_i) || $past(addr_i) != refclk_pkg::OFS_REF_B_CFG
			|| ref_out_b_oe_o == $past(wdata_i[6]));
	endproperty
	a_oe_b: assert property (p_oe_b) else $error("output B drives while disabled");

	property p_rx_float;
		@(posedge clk_i) disable iff (!rst_b_i)
		(rx_diff_mode_i && !rx_impedance_match_select_i) |->
			(&rx_hiz_o) && (rx_term_o == '0) && (rx_120ohm_select_o == '0);
	endproperty
	a_rx_float: assert property (p_rx_float) else $error("receivers not floated");

	property p_rx_apply;
		@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == refclk_pkg::OFS_TERM_BASE) ##1 (rx_diff_mode_i && rx_impedance_match_select_i)
			|-> (rx_term_o[2:0] == $past(wdata_i[2:0])) && (rx_120ohm_select_o[0] == $past(wdata_i[4]));
	endproperty
	a_rx_apply: assert property (p_rx_apply) else $error("channel termination not applied");

	property p_common_mode;
		@(posedge clk_i) disable iff (!rst_b_i)
		$changed(common_mode_out_enable_pin_i) |-> (common_mode_outputs_en_o == {2{common_mode_out_enable_pin_i}});
	endproperty
	a_common_mode: assert property (p_common_mode) else $error("common-mode gating wrong");

endmodule // refclk_sel
`default_nettype wire

// ### testbench/refclk_src_model.sv
/*
 * Far-side clock sources: one recovered clock per channel and the two
 * external reference clocks, all as slow levels.
 * Assumes the consumer samples them on the rising edge of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module refclk_src_model #(
	parameter int N_CH       = 17,
	parameter int EXT_A_HALF = 23,
	parameter int EXT_B_HALF = 25
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_b_i,
	// sources
	output logic [N_CH-1:0]      rec_clk_o,
	output logic                 ext_a_o,
	output logic                 ext_b_o
);
	// ************************************************************
	// toggle counters
	// ************************************************************
	// each source gets its own half period so a wrong route shows as a wrong rate
	int               cnt_q [N_CH+2];
	logic [N_CH+1:0]  lvl_q;

	function automatic int half_of(input int i);
		return (i < N_CH) ? 5 + i : ((i == N_CH) ? EXT_A_HALF : EXT_B_HALF);
	endfunction

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < N_CH + 2; i++) begin
			if (!rst_b_i) begin
				cnt_q[i] <= 0;
				lvl_q[i] <= 1'b0;
			end else if (cnt_q[i] >= half_of(i) - 1) begin
				cnt_q[i] <= 0;
				lvl_q[i] <= ~lvl_q[i];
			end else begin
				cnt_q[i] <= cnt_q[i] + 1;
			end
		end
	end

	assign rec_clk_o = lvl_q[N_CH-1:0];
	assign ext_a_o   = lvl_q[N_CH];
	assign ext_b_o   = lvl_q[N_CH+1];
endmodule // refclk_src_model
`default_nettype wire

// ### testbench/reference_clock_output_select_test.sv
/*
 * Self-checking bench for the reference clock output select block.
 * Assumes refclk_sel, refclk_pkg and the source model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_select_test;
	localparam int N_CH = 17;
	localparam int WIN  = 1200;

	logic              clk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	logic [7:0]        addr_i = 8'h00;
	logic [7:0]        wdata_i = 8'h00;
	logic              wr_i = 1'b0;
	logic              rd_i = 1'b0;
	logic              diff_i = 1'b0;
	logic              match_i = 1'b0;
	logic              cm_pin_i = 1'b0;
	wire logic [7:0]   rdata_o;
	wire logic [N_CH-1:0] rec_clk;
	wire logic         ext_a;
	wire logic         ext_b;
	wire logic         out_a, oe_a, out_b, oe_b;
	wire logic [N_CH*3-1:0] term_o;
	wire logic [N_CH-1:0] r120_o, hiz_o;
	wire logic [1:0]   cm_o;
	int                err_count = 0;
	int                checks_done = 0;

	refclk_src_model #(.N_CH(N_CH)) src_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.rec_clk_o(rec_clk), .ext_a_o(ext_a), .ext_b_o(ext_b));

	refclk_sel #(.N_CH(N_CH)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rec_clk_i(rec_clk), .ext_clock_in_a_i(ext_a), .ext_clock_in_b_i(ext_b),
		.ref_out_a_o(out_a), .ref_out_a_oe_o(oe_a), .ref_out_b_o(out_b),
		.ref_out_b_oe_o(oe_b), .rx_diff_mode_i(diff_i),
		.rx_impedance_match_select_i(match_i), .rx_term_o(term_o),
		.rx_120ohm_select_o(r120_o), .rx_hiz_o(hiz_o),
		.common_mode_out_enable_pin_i(cm_pin_i), .common_mode_outputs_en_o(cm_o));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic test_reset();
		logic [7:0] d;
		reg_rd(refclk_pkg::OFS_REF_A_CFG, d);
		check(d === refclk_pkg::RST_REF_CFG, "cfg a reset");
		@(posedge clk_i);
		#1 check(rdata_o === 8'h00, "read data held too long");
		reg_rd(refclk_pkg::OFS_REF_B_ROUTE, d);
		check(d === refclk_pkg::RST_REF_ROUTE, "route b reset");
		reg_rd(refclk_pkg::OFS_TERM_BASE + 8'h10, d);
		check(d === refclk_pkg::RST_TERM_CFG, "term reset");
		reg_wr(8'h21, 8'hFF);
		reg_rd(8'h21, d);
		check(d === 8'h00, "unmapped read");
		check(oe_a === 1'b0 && oe_b === 1'b0, "outputs float after reset");
		$display("test reset done");
	endtask

	task automatic test_enable();
		reg_wr(refclk_pkg::OFS_REF_A_CFG, 8'h40);
		check(oe_a === 1'b1 && oe_b === 1'b0, "enable a");
		reg_wr(refclk_pkg::OFS_REF_B_CFG, 8'h40);
		check(oe_b === 1'b1, "enable b");
		reg_wr(refclk_pkg::OFS_REF_A_CFG, 8'h00);
		reg_wr(refclk_pkg::OFS_REF_B_CFG, 8'h00);
		repeat (100) begin
			@(posedge clk_i);
			#1 if (oe_a !== 1'b0 || oe_b !== 1'b0 || out_a !== 1'b0 || out_b !== 1'b0)
				check(1'b0, "disabled output driven");
		end
		$display("test enable done");
	endtask

	// src: channel index, N_CH for input a, N_CH+1 for input b, -1 for free-running
	task automatic measure(input bit is_b, input logic [7:0] cfg, input logic [7:0] route,
		input int src, input int exp_free);
		logic [7:0] st;
		int n, tog, rises, ex;
		logic s, o, ps, po;
		n = 0;
		tog = 0;
		rises = 0;
		reg_wr(is_b ? refclk_pkg::OFS_REF_B_CFG : refclk_pkg::OFS_REF_A_CFG, cfg);
		reg_wr(is_b ? refclk_pkg::OFS_REF_B_ROUTE : refclk_pkg::OFS_REF_A_ROUTE, route);
		do begin
			reg_rd(refclk_pkg::OFS_STATUS, st);
			n++;
		end while (st[is_b ? 3 : 2] !== 1'b0 && n < 300);
		if (n >= 300) begin
			check(1'b0, "switch never finished");
			wrap_up();
		end
		ps = 1'b1;
		po = is_b ? out_b : out_a;
		repeat (WIN) begin
			@(posedge clk_i);
			#1 s = (src < 0) ? 1'b0 : (src < N_CH) ? rec_clk[src] : (src == N_CH) ? ext_a : ext_b;
			o = is_b ? out_b : out_a;
			if (s === 1'b1 && ps === 1'b0)
				rises++;
			if (o !== po)
				tog++;
			ps = s;
			po = o;
		end
		ex = (src < 0) ? exp_free : rises / (int'(cfg[3:0]) + 1);
		check(tog >= ex - 1 && tog <= ex + 1, "output rate or source wrong");
		$display("test route %0h done", route);
	endtask

	task automatic test_term();
		logic [7:0] d;
		reg_wr(refclk_pkg::OFS_TERM_BASE + 8'h05, 8'h15);
		reg_rd(refclk_pkg::OFS_TERM_BASE + 8'h05, d);
		check(d === 8'h15, "term readback");
		@(posedge clk_i);
		diff_i  <= 1'b1;
		match_i <= 1'b0;
		@(posedge clk_i);
		#1 check(hiz_o === {N_CH{1'b1}} && term_o === '0 && r120_o === '0, "receivers not floated");
		@(posedge clk_i);
		match_i <= 1'b1;
		@(posedge clk_i);
		#1 check(hiz_o[5] === 1'b0 && term_o[17:15] === 3'h5 && r120_o[5] === 1'b1, "ch5");
		check(term_o[20:18] === 3'h0 && r120_o[6] === 1'b0, "ch6 term");
		reg_wr(refclk_pkg::OFS_TERM_BASE, 8'h13);
		check(term_o[2:0] === 3'h3 && r120_o[0] === 1'b1 && hiz_o[0] === 1'b0, "ch0 term");
		@(posedge clk_i);
		diff_i <= 1'b0;
		@(posedge clk_i);
		#1 check(hiz_o === {N_CH{1'b0}} && term_o[17:15] === 3'h5, "single ended");
		$display("test term done");
	endtask

	task automatic test_cm();
		@(posedge clk_i);
		cm_pin_i <= 1'b0;
		@(posedge clk_i);
		#1 check(cm_o === 2'b00, "common mode on while pin low");
		@(posedge clk_i);
		cm_pin_i <= 1'b1;
		@(posedge clk_i);
		#1 check(cm_o === 2'b11, "common mode off while pin high");
		$display("test common mode done");
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		test_reset();
		test_enable();
		// external A stands in for the faster rate and gets bit 5, external B for the slower
		measure(1'b0, 8'h60, 8'h20, N_CH, 0);
		measure(1'b0, 8'h41, 8'h03, 3, 0);
		// channel 21 does not exist and must fall back to channel 0
		measure(1'b0, 8'h40, 8'h15, 0, 0);
		measure(1'b0, 8'h40, 8'h40, -1, WIN / (2 * int'(refclk_pkg::FREE_T1_HALF)));
		measure(1'b0, 8'h60, 8'h40, -1, WIN / (2 * int'(refclk_pkg::FREE_E1_HALF)));
		measure(1'b1, 8'h40, 8'h10, 16, 0);
		measure(1'b1, 8'h42, 8'h20, N_CH + 1, 0);
		measure(1'b1, 8'h40, 8'h60, -1, WIN / (2 * int'(refclk_pkg::FREE_T1_HALF)));
		test_term();
		test_cm();
		wrap_up();
	end
endmodule // reference_clock_output_select_test
`default_nettype wire
